//--- hdl/hyp_fence_pkg.sv
// Constants and carrier types for the hypervisor fence and status control
package hyp_fence_pkg;

   localparam int XLEN = 64;

   // Identifier widths: architected maximum and implemented length
   localparam int SPACE_ID_LEN_MAX    = 16;
   localparam int SPACE_ID_LEN_IMPL   = 9;
   localparam int MACHINE_ID_LEN_MAX  = 14;
   localparam int MACHINE_ID_LEN_IMPL = 7;

   // Guest physical address operand shift
   localparam int GPA_SHIFT = 2;

   // Field positions in the wide machine status word
   localparam int MS_PREV_VIRT = 39;
   localparam int MS_GUEST_ADDR = 38;
   localparam int MS_TSR = 22;
   localparam int MS_TW = 21;
   localparam int MS_TVM = 20;
   localparam int MS_MODIFY_PRIV_BIT = 17;
   localparam int MS_MPP_LO = 11;

   // Field positions in the upper-half status word
   localparam int MSH_PREV_VIRT = 7;
   localparam int MSH_GUEST_ADDR = 6;

   // Privilege encodings
   localparam logic [1:0] PRIV_U = 2'h0;
   localparam logic [1:0] PRIV_S = 2'h1;
   localparam logic [1:0] PRIV_M = 2'h3;

   // APB register map (byte addresses)
   localparam logic [11:0] ADDR_STATUS_LO   = 12'h000;
   localparam logic [11:0] ADDR_STATUS_HI   = 12'h004;
   localparam logic [11:0] ADDR_STATUS_H32  = 12'h008;
   localparam logic [11:0] ADDR_CTRL        = 12'h00C;
   localparam logic [11:0] ADDR_FENCE_STAT  = 12'h010;
   localparam logic [11:0] ADDR_GUEST_ID    = 12'h014;

   localparam logic [63:0] STATUS_RESET = 64'h0000_0000_0000_0000;

   typedef enum logic [1:0] { EXC_NONE, EXC_ILLEGAL, EXC_VIRTUAL } exc_type;

   typedef enum logic [1:0] { FLUSH_NONE, FLUSH_VS_STAGE, FLUSH_G_STAGE } scope_type;

   // Instruction request from the pipeline
   typedef struct packed {
      logic            va_fence;
      logic            pa_fence;
      logic            pa_inval;
      logic            va_inval;
      logic            rs1_zero;
      logic            rs2_zero;
      logic [XLEN-1:0] rs1_val;
      logic [XLEN-1:0] rs2_val;
   } fence_req_type;

   // Flush command towards the translation caches
   typedef struct packed {
      logic                           valid;
      scope_type                      scope;
      logic                           addr_all;
      logic                           id_all;
      logic [XLEN-1:0]                addr;
      logic [SPACE_ID_LEN_MAX-1:0]    space_id;
      logic [MACHINE_ID_LEN_MAX-1:0]  machine_id;
      logic                           order_stores;
   } flush_type;

   // Trap event into machine mode
   typedef struct packed {
      logic       take;
      logic       guest_va;
      logic [1:0] from_priv;
      logic       from_virt;
   } trap_type;

   // Effective mode for explicit memory accesses
   typedef struct packed {
      logic       virt;
      logic [1:0] priv;
   } eff_mode_type;

endpackage

//--- hdl/hypervisor_fence_status_ctrl.sv
// Guest fence legality, flush decode and hypervisor status fields
`timescale 1ns/100ps

module hypervisor_fence_status_ctrl #(
   parameter bit SIMPLE_FENCE = 1'b0,
   parameter bit COMBINED_TLB = 1'b1
) (
   input  wire logic                                          sys_clk_in,
   input  wire logic                                          srst_in,
   // APB slave
   input  wire logic                                          psel_in,
   input  wire logic                                          penable_in,
   input  wire logic                                          pwrite_in,
   input  wire logic [11:0]                                   paddr_in,
   input  wire logic [31:0]                                   pwdata_in,
   output logic      [31:0]                                   prdata_out,
   output logic                                               pready_out,
   output logic                                               pslverr_out,
   // Hart state
   input  wire logic [1:0]                                    cur_priv_in,
   input  wire logic                                          virt_mode_in,
   input  wire logic [hyp_fence_pkg::MACHINE_ID_LEN_MAX-1:0]  guest_machine_id_in,
   input  wire hyp_fence_pkg::fence_req_type                  fence_req_in,
   input  wire logic                                          gst_reg_access_in,
   input  wire logic                                          sret_in,
   input  wire logic                                          wfi_in,
   input  wire logic                                          vm_ldst_in,
   input  wire hyp_fence_pkg::trap_type                       trap_in,
   input  wire logic                                          machine_return_in,
   output hyp_fence_pkg::exc_type                             exc_out,
   output hyp_fence_pkg::flush_type                           flush_out,
   output logic                                               gst_reg_block_out,
   output logic                                               sret_trap_out,
   output logic                                               wfi_trap_out,
   output logic                                               virt_mode_out,
   output logic                                               virt_mode_set_out,
   output hyp_fence_pkg::eff_mode_type                        eff_mode_out
);

   localparam int SL = hyp_fence_pkg::SPACE_ID_LEN_MAX;
   localparam int ML = hyp_fence_pkg::MACHINE_ID_LEN_MAX;

   // Every check below samples the hart clock and is off in reset
   default clocking chk_clk @(posedge sys_clk_in);
   endclocking
   default disable iff (srst_in);

   logic [63:0]                  status_r;
   logic [3:0]                   ctrl_r;
   logic [31:0]                  fence_cnt_r;
   logic [ML-1:0]                last_id_r;
   hyp_fence_pkg::exc_type       exc_nxt;
   hyp_fence_pkg::flush_type     flush_nxt;
   logic                         hs_mode;
   logic                         trap_vm_ops_bit;
   logic [SL-1:0]                space_mask;
   logic [ML-1:0]                id_mask;
   logic                         apb_wr;
   logic                         apb_rd;

   assign hs_mode = (cur_priv_in == hyp_fence_pkg::PRIV_S) && !virt_mode_in;
   assign trap_vm_ops_bit     = status_r[hyp_fence_pkg::MS_TVM];
   assign apb_wr  = psel_in && penable_in && pwrite_in;
   assign apb_rd  = psel_in && !pwrite_in;

   // Masks that keep only implemented identifier bits
   genvar gi;
   generate
      for (gi = 0; gi < SL; gi++)
      begin : g_space_mask
         assign space_mask[gi] = (gi < hyp_fence_pkg::SPACE_ID_LEN_IMPL);
      end
      for (gi = 0; gi < ML; gi++)
      begin : g_id_mask
         assign id_mask[gi] = (gi < hyp_fence_pkg::MACHINE_ID_LEN_IMPL);
      end
   endgenerate

   // Fence legality, then flush command only for legal fences
   always_comb
   begin
      exc_nxt   = hyp_fence_pkg::EXC_NONE;
      flush_nxt = '0;
      if (fence_req_in.va_fence || fence_req_in.pa_fence)
      begin
         if (virt_mode_in)
            exc_nxt = hyp_fence_pkg::EXC_VIRTUAL;
         else if (cur_priv_in == hyp_fence_pkg::PRIV_U)
            exc_nxt = hyp_fence_pkg::EXC_ILLEGAL;
         else if (fence_req_in.pa_fence && hs_mode && trap_vm_ops_bit)
            exc_nxt = hyp_fence_pkg::EXC_ILLEGAL;
         // Virtual fence never checks trap-vm bits
      end
      else if (fence_req_in.pa_inval && hs_mode && trap_vm_ops_bit)
         exc_nxt = hyp_fence_pkg::EXC_ILLEGAL;
      else if (fence_req_in.va_inval && virt_mode_in)
         exc_nxt = hyp_fence_pkg::EXC_VIRTUAL;
      if (exc_nxt == hyp_fence_pkg::EXC_NONE)
      begin
         if (fence_req_in.va_fence)
         begin
            flush_nxt.valid    = 1'b1;
            flush_nxt.scope    = hyp_fence_pkg::FLUSH_VS_STAGE;
            flush_nxt.addr_all = fence_req_in.rs1_zero || SIMPLE_FENCE;
            flush_nxt.id_all   = fence_req_in.rs2_zero || SIMPLE_FENCE;
            flush_nxt.addr     = fence_req_in.rs1_val;
            flush_nxt.space_id = fence_req_in.rs2_val[SL-1:0] & space_mask;
            // Restrict to the guest currently installed; SIMPLE_FENCE sends machine id zero instead
            flush_nxt.machine_id = SIMPLE_FENCE ? '0 : guest_machine_id_in;
            flush_nxt.order_stores = 1'b1;
         end
         else if (fence_req_in.pa_fence)
         begin
            flush_nxt.valid    = 1'b1;
            flush_nxt.scope    = hyp_fence_pkg::FLUSH_G_STAGE;
            // Combined caches drop address filter and flush by id
            flush_nxt.addr_all = fence_req_in.rs1_zero || SIMPLE_FENCE
                                 || COMBINED_TLB;
            flush_nxt.id_all   = fence_req_in.rs2_zero || SIMPLE_FENCE;
            flush_nxt.addr     = fence_req_in.rs1_val << hyp_fence_pkg::GPA_SHIFT;
            flush_nxt.machine_id = fence_req_in.rs2_val[ML-1:0] & id_mask;
            flush_nxt.order_stores = 1'b1;
         end
      end
   end

   // Registered exception and flush outputs
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         exc_out   <= hyp_fence_pkg::EXC_NONE;
         flush_out <= '0;
      end
      else
      begin
         exc_out   <= exc_nxt;
         flush_out <= flush_nxt;
      end
   end

   // Trap gating outputs
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         gst_reg_block_out <= 1'b0;
         sret_trap_out     <= 1'b0;
         wfi_trap_out      <= 1'b0;
      end
      else
      begin
         gst_reg_block_out <= gst_reg_access_in && hs_mode && trap_vm_ops_bit;
         sret_trap_out <= sret_in && hs_mode
                          && status_r[hyp_fence_pkg::MS_TSR];
         wfi_trap_out <= wfi_in && (cur_priv_in != hyp_fence_pkg::PRIV_M)
                         && status_r[hyp_fence_pkg::MS_TW];
      end
   end

   // Status word: trap capture and software writes
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         status_r <= hyp_fence_pkg::STATUS_RESET;
      else if (trap_in.take)
      begin
         status_r[hyp_fence_pkg::MS_PREV_VIRT] <= trap_in.from_virt;
         status_r[hyp_fence_pkg::MS_GUEST_ADDR] <= trap_in.guest_va;
         status_r[hyp_fence_pkg::MS_MPP_LO +: 2] <= trap_in.from_priv;
      end
      else if (apb_wr && paddr_in == hyp_fence_pkg::ADDR_STATUS_LO)
         status_r[31:0] <= pwdata_in;
      else if (apb_wr && paddr_in == hyp_fence_pkg::ADDR_STATUS_HI)
         status_r[63:32] <= pwdata_in;
      else if (apb_wr && paddr_in == hyp_fence_pkg::ADDR_STATUS_H32)
      begin
         status_r[hyp_fence_pkg::MS_PREV_VIRT]  <= pwdata_in[hyp_fence_pkg::MSH_PREV_VIRT];
         status_r[hyp_fence_pkg::MS_GUEST_ADDR] <= pwdata_in[hyp_fence_pkg::MSH_GUEST_ADDR];
      end
   end

   // Virtualization mode restored on machine return
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         virt_mode_out     <= 1'b0;
         virt_mode_set_out <= 1'b0;
      end
      else
      begin
         virt_mode_set_out <= machine_return_in;
         if (machine_return_in)
            virt_mode_out <= (status_r[hyp_fence_pkg::MS_MPP_LO +: 2] == hyp_fence_pkg::PRIV_M)
                             ? 1'b0 : status_r[hyp_fence_pkg::MS_PREV_VIRT];
      end
   end

   // Effective mode of explicit accesses
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         eff_mode_out <= '0;
      else if (vm_ldst_in)
         eff_mode_out <= '{virt: 1'b1, priv: ctrl_r[1:0]};
      else if (status_r[hyp_fence_pkg::MS_MODIFY_PRIV_BIT])
         eff_mode_out <= '{virt: status_r[hyp_fence_pkg::MS_PREV_VIRT],
                           priv: status_r[hyp_fence_pkg::MS_MPP_LO +: 2]};
      else
         eff_mode_out <= '{virt: virt_mode_in, priv: cur_priv_in};
   end

   // Control (guest privilege for vm loads) and fence statistics
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         ctrl_r <= '0;
      else if (apb_wr && paddr_in == hyp_fence_pkg::ADDR_CTRL)
         ctrl_r <= pwdata_in[3:0];
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         fence_cnt_r <= '0;
         last_id_r   <= '0;
      end
      else if (flush_nxt.valid)
      begin
         fence_cnt_r <= fence_cnt_r + 32'h0000_0001;
         last_id_r   <= flush_nxt.machine_id;
      end
   end

   // APB read path, zero wait states
   assign pready_out  = 1'b1;
   assign pslverr_out = 1'b0;
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         prdata_out <= '0;
      else if (apb_rd && !penable_in)
         unique case (paddr_in)
            hyp_fence_pkg::ADDR_STATUS_LO:  prdata_out <= status_r[31:0];
            hyp_fence_pkg::ADDR_STATUS_HI:  prdata_out <= status_r[63:32];
            hyp_fence_pkg::ADDR_STATUS_H32: prdata_out <= 32'({status_r[hyp_fence_pkg::MS_PREV_VIRT],
                                               status_r[hyp_fence_pkg::MS_GUEST_ADDR]})
                                               << hyp_fence_pkg::MSH_GUEST_ADDR;
            hyp_fence_pkg::ADDR_CTRL:       prdata_out <= 32'(ctrl_r);
            hyp_fence_pkg::ADDR_FENCE_STAT: prdata_out <= fence_cnt_r;
            hyp_fence_pkg::ADDR_GUEST_ID:   prdata_out <= 32'(last_id_r);
            default:                        prdata_out <= '0;
         endcase
   end

   // Checks next to the logic
   a_virt_fence_exc: assert property (
      (fence_req_in.va_fence && virt_mode_in) |=> exc_out == hyp_fence_pkg::EXC_VIRTUAL)
      else $error("virtualized fence not virtual exception");

   a_user_fence_exc: assert property (
      (fence_req_in.pa_fence && !virt_mode_in && cur_priv_in == hyp_fence_pkg::PRIV_U)
      |=> exc_out == hyp_fence_pkg::EXC_ILLEGAL)
      else $error("user fence not illegal");

   a_tvm_pa_exc: assert property (
      (fence_req_in.pa_fence && hs_mode && trap_vm_ops_bit) |=> exc_out == hyp_fence_pkg::EXC_ILLEGAL)
      else $error("trap-vm physical fence accepted");

   a_va_no_tvm: assert property (
      (fence_req_in.va_fence && hs_mode) |=> exc_out == hyp_fence_pkg::EXC_NONE)
      else $error("virtual fence trapped in hypervisor mode");

   a_trap_no_flush: assert property (
      exc_out != hyp_fence_pkg::EXC_NONE |-> !flush_out.valid)
      else $error("trapping fence flushed");

   a_prev_virt_save: assert property (
      trap_in.take |=> status_r[hyp_fence_pkg::MS_PREV_VIRT] == $past(trap_in.from_virt))
      else $error("previous virt not saved");

   a_machine_return_virt: assert property (
      (machine_return_in && status_r[hyp_fence_pkg::MS_MPP_LO +: 2] == hyp_fence_pkg::PRIV_M)
      |=> !virt_mode_out)
      else $error("return to machine set virt");

   a_guest_addr_flag: assert property (
      trap_in.take |=> status_r[hyp_fence_pkg::MS_GUEST_ADDR] == $past(trap_in.guest_va))
      else $error("guest address flag wrong");

   a_space_id_mask: assert property (
      flush_out.valid |-> (flush_out.space_id & ~space_mask) == '0)
      else $error("unimplemented space id bits kept");

   a_user_va_exc: assert property (
      (fence_req_in.va_fence && !virt_mode_in && cur_priv_in == hyp_fence_pkg::PRIV_U)
      |=> exc_out == hyp_fence_pkg::EXC_ILLEGAL)
      else $error("user virtual fence not illegal");

   a_m_pa_legal: assert property (
      (fence_req_in.pa_fence && !virt_mode_in && cur_priv_in == hyp_fence_pkg::PRIV_M)
      |=> exc_out == hyp_fence_pkg::EXC_NONE && flush_out.valid)
      else $error("machine physical fence refused");

   a_hs_pa_legal: assert property (
      (fence_req_in.pa_fence && hs_mode && !trap_vm_ops_bit)
      |=> exc_out == hyp_fence_pkg::EXC_NONE && flush_out.valid)
      else $error("hypervisor physical fence refused");

   a_pa_addr_shift: assert property (
      (fence_req_in.pa_fence && !fence_req_in.va_fence && !virt_mode_in
       && cur_priv_in == hyp_fence_pkg::PRIV_M)
      |=> flush_out.addr == ($past(fence_req_in.rs1_val) << hyp_fence_pkg::GPA_SHIFT))
      else $error("physical fence address not shifted");

   a_pa_id_mask: assert property (
      (flush_out.valid && flush_out.scope == hyp_fence_pkg::FLUSH_G_STAGE)
      |-> (flush_out.machine_id & ~id_mask) == '0)
      else $error("unimplemented machine id bits kept");

   a_va_id_current: assert property (
      (!SIMPLE_FENCE && fence_req_in.va_fence && !virt_mode_in
       && cur_priv_in == hyp_fence_pkg::PRIV_M)
      |=> flush_out.machine_id == $past(guest_machine_id_in))
      else $error("virtual fence guest id not current");

   a_zero_addr_all: assert property (
      (fence_req_in.va_fence && fence_req_in.rs1_zero && !virt_mode_in
       && cur_priv_in == hyp_fence_pkg::PRIV_M)
      |=> flush_out.addr_all)
      else $error("zero address operand kept a filter");

   a_tvm_reg_block: assert property (
      (gst_reg_access_in && hs_mode && trap_vm_ops_bit) |=> gst_reg_block_out)
      else $error("guest translation access not blocked");

   a_machine_return_prev_virt: assert property (
      (machine_return_in && status_r[hyp_fence_pkg::MS_MPP_LO +: 2] != hyp_fence_pkg::PRIV_M)
      |=> virt_mode_out == $past(status_r[hyp_fence_pkg::MS_PREV_VIRT]))
      else $error("return did not restore virt");

   a_modify_priv_bit_mode: assert property (
      (!vm_ldst_in && status_r[hyp_fence_pkg::MS_MODIFY_PRIV_BIT])
      |=> eff_mode_out.virt == $past(status_r[hyp_fence_pkg::MS_PREV_VIRT]))
      else $error("modify-priv access mode wrong");

   a_vm_ldst_virt: assert property (
      vm_ldst_in |=> eff_mode_out.virt)
      else $error("vm access not virtualized");

endmodule

//--- verification/hypervisor_fence_status_ctrl_bench.sv
// Self-checking bench for the hypervisor fence and status control
`timescale 1ns/100ps
module hypervisor_fence_status_ctrl_bench;
   logic                               sys_clk_in, srst_in, psel_in, penable_in, pwrite_in;
   logic [11:0]                        paddr_in;
   logic [31:0]                        pwdata_in, prdata_out, rd;
   logic                               pready_out, pslverr_out;
   logic [1:0]                         cur_priv_in;
   logic                               virt_mode_in, gst_reg_access_in, sret_in, wfi_in;
   logic                               vm_ldst_in, machine_return_in, tvm_now;
   logic [13:0]                        guest_machine_id_in;
   hyp_fence_pkg::fence_req_type       fence_req_in;
   hyp_fence_pkg::trap_type            trap_in;
   hyp_fence_pkg::exc_type             exc_out, ex;
   hyp_fence_pkg::flush_type           flush_out;
   logic                               gst_reg_block_out, sret_trap_out, wfi_trap_out;
   logic                               virt_mode_out, virt_mode_set_out;
   hyp_fence_pkg::eff_mode_type        eff_mode_out;
   int                                 miscompares, n_compared, cycles, legal_n;
   integer                             seed;

   hypervisor_fence_status_ctrl DUT (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
      .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .cur_priv_in(cur_priv_in), .virt_mode_in(virt_mode_in),
      .guest_machine_id_in(guest_machine_id_in), .fence_req_in(fence_req_in),
      .gst_reg_access_in(gst_reg_access_in), .sret_in(sret_in), .wfi_in(wfi_in),
      .vm_ldst_in(vm_ldst_in), .trap_in(trap_in), .machine_return_in(machine_return_in), .exc_out(exc_out),
      .flush_out(flush_out), .gst_reg_block_out(gst_reg_block_out),
      .sret_trap_out(sret_trap_out), .wfi_trap_out(wfi_trap_out),
      .virt_mode_out(virt_mode_out), .virt_mode_set_out(virt_mode_set_out),
      .eff_mode_out(eff_mode_out));

   // Clock at 100 ns period
   initial
   begin
      sys_clk_in = 1'b0;
      forever #50 sys_clk_in = ~sys_clk_in;
   end

   // Compare and count
   task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task test_done;
      $display("Compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Hang guard
   always @(posedge sys_clk_in)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         test_done();
      end
   end

   // One APB transfer, held until pready is seen
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge sys_clk_in);
      penable_in <= 1'b1;
      do @(posedge sys_clk_in); while (pready_out !== 1'b1);
      rd = prdata_out;
      check("slverr", pslverr_out, 1'b0);
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask

   // Low status word from its control fields
   function automatic logic [31:0] lo_word(input logic trap_sret_bit, tw, trap_vm_ops_bit, modify_priv_bit, input logic [1:0] prev_priv_field);
      return {9'h000, trap_sret_bit, tw, trap_vm_ops_bit, 2'b00, modify_priv_bit, 4'h0, prev_priv_field, 11'h000};
   endfunction

   task wstat(input logic trap_sret_bit, tw, trap_vm_ops_bit, modify_priv_bit, input logic [1:0] prev_priv_field);
      tvm_now = trap_vm_ops_bit;
      apb(1'b1, hyp_fence_pkg::ADDR_STATUS_LO, lo_word(trap_sret_bit, tw, trap_vm_ops_bit, modify_priv_bit, prev_priv_field));
   endtask

   // Fence of kind k: 0 va, 1 pa, 2 va invalidate, 3 pa invalidate
   task fence(input int k, input logic [1:0] p, input logic v);
      logic        z1, z2, leg;
      logic [63:0] r1, r2;
      logic [13:0] gid;
      z1 = $random(seed);
      z2 = $random(seed);
      r1 = z1 ? 64'h0 : {$random(seed), $random(seed)};
      r2 = z2 ? 64'h0 : {$random(seed), $random(seed)};
      gid = {7'h00, 7'($random(seed))};
      @(posedge sys_clk_in);
      cur_priv_in <= p;
      virt_mode_in <= v;
      guest_machine_id_in <= gid;
      fence_req_in <= '{va_fence: k == 0, pa_fence: k == 1, pa_inval: k == 3, va_inval: k == 2,
                        rs1_zero: z1, rs2_zero: z2, rs1_val: r1, rs2_val: r2};
      @(posedge sys_clk_in);
      fence_req_in <= '0;
      #1;
      ex = v ? hyp_fence_pkg::EXC_VIRTUAL : (p == hyp_fence_pkg::PRIV_U) ?
           hyp_fence_pkg::EXC_ILLEGAL : (k[0] && p == hyp_fence_pkg::PRIV_S && tvm_now) ?
           hyp_fence_pkg::EXC_ILLEGAL : hyp_fence_pkg::EXC_NONE;
      leg = (ex == hyp_fence_pkg::EXC_NONE) && k < 2;
      check("exc", exc_out, ex);
      check("flush valid", flush_out.valid, leg);
      if (leg && k == 0)
      begin
         legal_n++;
         check("va scope", flush_out.scope, hyp_fence_pkg::FLUSH_VS_STAGE);
         check("va addr all", flush_out.addr_all, z1);
         check("va id all", flush_out.id_all, z2);
         check("va machine id", flush_out.machine_id, gid);
         if (!z1) check("va addr", flush_out.addr, r1);
         if (!z2) check("va space id", flush_out.space_id, r2[8:0]);
      end
      if (leg && k == 1)
      begin
         legal_n++;
         check("pa scope", flush_out.scope, hyp_fence_pkg::FLUSH_G_STAGE);
         check("pa addr all", flush_out.addr_all, 1'b1);
         check("pa id all", flush_out.id_all, z2);
         check("pa order", flush_out.order_stores, 1'b1);
         if (!z1) check("pa addr", flush_out.addr, r1 << hyp_fence_pkg::GPA_SHIFT);
         if (!z2) check("pa machine id", flush_out.machine_id, r2[6:0]);
      end
   endtask

   // Trap into machine mode, then read both status views
   task trap(input logic fv, input logic guest_addr_flag);
      @(posedge sys_clk_in);
      trap_in <= '{take: 1'b1, guest_va: guest_addr_flag, from_priv: hyp_fence_pkg::PRIV_S, from_virt: fv};
      @(posedge sys_clk_in);
      trap_in <= '0;
      apb(1'b0, hyp_fence_pkg::ADDR_STATUS_HI, 32'h0000_0000);
      check("prev virt", rd[7], fv);
      check("guest addr", rd[6], guest_addr_flag);
      apb(1'b0, hyp_fence_pkg::ADDR_STATUS_H32, 32'h0000_0000);
      check("upper view", rd[7:6], {fv, guest_addr_flag});
   endtask

   // Main sequence
   initial
   begin
      int p, v, k, t, b;
      seed = 32'hb766;
      {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
      {cur_priv_in, virt_mode_in, guest_machine_id_in, gst_reg_access_in} = '0;
      {sret_in, wfi_in, vm_ldst_in, machine_return_in, tvm_now, fence_req_in, trap_in} = '0;
      srst_in = 1'b1;
      repeat (4) @(posedge sys_clk_in);
      srst_in <= 1'b0;
      #1;
      check("reset exc", exc_out, hyp_fence_pkg::EXC_NONE);
      check("reset virt", virt_mode_out, 1'b0);
      apb(1'b0, hyp_fence_pkg::ADDR_STATUS_LO, 32'h0000_0000);
      check("reset status lo", rd, hyp_fence_pkg::STATUS_RESET[31:0]);
      apb(1'b1, 12'h020, 32'hffff_ffff);
      apb(1'b0, 12'h020, 32'h0000_0000);
      check("unmapped read", rd, 32'h0000_0000);
      // Legality and operand decode over every mode
      for (t = 0; t < 2; t++)
      begin
         wstat(1'b0, 1'b0, t[0], 1'b0, 2'b00);
         for (p = 0; p < 4; p++)
            for (v = 0; v < 2; v++)
               for (k = 0; k < 2; k++)
                  if (p != 2 && !(p == 3 && v == 1)) fence(k, p[1:0], v[0]);
      end
      apb(1'b0, hyp_fence_pkg::ADDR_FENCE_STAT, 32'h0000_0000);
      check("fence count", rd, 32'(legal_n));
      // Global physical fence as software issues after a translation mode change
      @(posedge sys_clk_in);
      cur_priv_in <= hyp_fence_pkg::PRIV_M;
      virt_mode_in <= 1'b0;
      fence_req_in <= '{pa_fence: 1'b1, rs1_zero: 1'b1, rs2_zero: 1'b1, default: '0};
      @(posedge sys_clk_in);
      fence_req_in <= '0;
      #1;
      check("mode fence", {flush_out.valid, flush_out.addr_all, flush_out.id_all}, 3'b111);
      fence(3, hyp_fence_pkg::PRIV_S, 1'b0);
      fence(2, hyp_fence_pkg::PRIV_S, 1'b1);
      // Guest-address and previous-virt capture
      for (b = 0; b < 4; b++) trap(b[1], b[0]);
      apb(1'b1, hyp_fence_pkg::ADDR_STATUS_H32, 32'h0000_0080);
      apb(1'b0, hyp_fence_pkg::ADDR_STATUS_HI, 32'h0000_0000);
      check("upper write", rd[7:6], 2'b10);
      // Machine return restores virtualization
      for (b = 0; b < 6; b++)
      begin
         trap(b[0], 1'b0);
         wstat(1'b0, 1'b0, 1'b0, 1'b0, (b < 4) ? {1'b0, b[1]} : 2'b11);
         @(posedge sys_clk_in);
         machine_return_in <= 1'b1;
         @(posedge sys_clk_in);
         machine_return_in <= 1'b0;
         #1;
         check("machine_return pulse", virt_mode_set_out, 1'b1);
         check("machine_return virt", virt_mode_out, (b < 4) ? b[0] : 1'b0);
      end
      // Trap controls in each mode
      for (t = 0; t < 2; t++)
      begin
         wstat(t[0], t[0], t[0], 1'b0, 2'b01);
         apb(1'b0, hyp_fence_pkg::ADDR_STATUS_LO, 32'h0000_0000);
         check("status fields", {rd[22:20], rd[12:11]}, {{3{t[0]}}, 2'b01});
         for (p = 0; p < 4; p++)
            for (v = 0; v < 2; v++)
               if (p != 2 && !(p == 3 && v == 1))
               begin
                  @(posedge sys_clk_in);
                  cur_priv_in <= p[1:0];
                  virt_mode_in <= v[0];
                  {sret_in, wfi_in, gst_reg_access_in} <= 3'b111;
                  @(posedge sys_clk_in);
                  {sret_in, wfi_in, gst_reg_access_in} <= 3'b000;
                  #1;
                  check("sret trap", sret_trap_out, t[0] && p == 1 && !v[0]);
                  check("wfi trap", wfi_trap_out, t[0] && p != 3);
                  check("guest reg block", gst_reg_block_out, t[0] && p == 1 && !v[0]);
               end
      end
      // Effective mode for explicit accesses
      trap(1'b1, 1'b0);
      wstat(1'b0, 1'b0, 1'b0, 1'b1, hyp_fence_pkg::PRIV_S);
      apb(1'b1, hyp_fence_pkg::ADDR_CTRL, 32'h0000_0000);
      @(posedge sys_clk_in);
      cur_priv_in <= hyp_fence_pkg::PRIV_M;
      virt_mode_in <= 1'b0;
      repeat (3) @(posedge sys_clk_in);
      #1;
      check("modify_priv_bit mode", eff_mode_out, {1'b1, hyp_fence_pkg::PRIV_S});
      @(posedge sys_clk_in);
      vm_ldst_in <= 1'b1;
      repeat (3) @(posedge sys_clk_in);
      #1;
      check("vm access mode", eff_mode_out, {1'b1, hyp_fence_pkg::PRIV_U});
      @(posedge sys_clk_in);
      vm_ldst_in <= 1'b0;
      wstat(1'b0, 1'b0, 1'b0, 1'b0, hyp_fence_pkg::PRIV_S);
      repeat (3) @(posedge sys_clk_in);
      #1;
      check("plain mode", eff_mode_out, {1'b0, hyp_fence_pkg::PRIV_M});
      test_done();
   end
endmodule
